// [design/cbs_pkg.sv]
package cbs_pkg;

    localparam logic [15:0] NMI_VECTOR    = 16'h0066;
    localparam logic [1:0]  IO_AUTO_WAIT  = 2'h1;
    localparam logic [7:0]  REFRESH_RESET = 8'h00;
    localparam logic        TX_IDLE       = 1'h1;
    localparam logic [8:0]  PIN_IDLE      = 9'h1ff;

    localparam int PIN_NMI  = 0;
    localparam int PIN_IRQ_LINE_ZERO = 1;
    localparam int PIN_IRQ_LINE_ONE = 2;
    localparam int PIN_IRQ_LINE_TWO = 3;
    localparam int PIN_WAIT = 4;
    localparam int PIN_BREQ = 5;
    localparam int PIN_ASYNC_CLOCK_ZERO = 6;
    localparam int PIN_ASYNC_CLOCK_ONE = 7;
    localparam int PIN_RXS  = 8;
    localparam int PIN_NUM  = 9;

    // Order is status, halt, first-cycle.
    localparam logic [2:0] ST_FETCH_FIRST = 3'h2;
    localparam logic [2:0] ST_FETCH_NEXT  = 3'h6;
    localparam logic [2:0] ST_OTHER       = 3'h7;
    localparam logic [2:0] ST_DMA         = 3'h3;
    localparam logic [2:0] ST_HALT        = 3'h0;
    localparam logic [2:0] ST_SLEEP       = 3'h5;

    typedef enum logic [3:0] {
        CYC_IDLE, CYC_FETCH, CYC_MEM_RD, CYC_MEM_WR, CYC_IO_RD, CYC_IO_WR,
        CYC_REFRESH, CYC_INTACK0, CYC_DMA_RD, CYC_DMA_WR
    } cbs_cycle_t;

    typedef enum logic [2:0] {BS_IDLE, BS_T1, BS_T2, BS_TW, BS_T3} cbs_state_t;

    typedef enum logic [1:0] {IRQ_NMI, IRQ_ZERO, IRQ_ONE, IRQ_TWO} cbs_irq_t;

    typedef struct packed {
        logic        valid;
        cbs_cycle_t  kind;
        logic        first_fetch;
        logic        last_dma;
        logic        dma_ch;
        logic [19:0] addr;
        logic [7:0]  wdata;
    } cbs_req_t;

    typedef struct packed {
        logic timer_pulse_out_hi;
        logic timer_pulse_out_lo;
        logic dma_dest_hi;
        logic dma_src_hi;
        logic async_clock_one_disable;
        logic clear_to_send_one_enable;
    } cbs_mux_cfg_t;

endpackage : cbs_pkg

// [design/cbs_bus_ctl.sv]
`timescale 1ns/10ps
// Notes on behaviour
// - Lines one, two serviced after zero; no strobes.
// - I/O strobe marks valid I/O address.
// - Line zero acknowledge drives I/O and first-cycle.
// - First-cycle only with fetch, interrupt acknowledge or halt.
// - Memory strobe marks valid memory address.
// - Falling-edge NMI wins, vectors to 0066.
// - Read strobe for memory or I/O reads.
// - Refresh strobe with memory strobe, low address.
// - Status, halt, first-cycle pins encode cycle.
// - Transfer-end low on final DMA write.
// - Transmit data changes on transmit clock fall.
// - Wait sampled at T2 fall, repeats.
// - Write strobe only while data valid.
// - Address 18 pin becomes timer output.
// - Clock-zero pin becomes DMA request zero.
// - Clock-one pin becomes transfer-end zero.
// - Serial receive pin becomes clear-to-send one.
// - System clock is reference divided by two.
// - Line zero serviced when NMI, bus request idle.
module cbs_bus_ctl
    import cbs_pkg::*;
(
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst,
    input  wire cbs_req_t     i_req,
    output logic              o_done,
    output logic [7:0]        o_rdata,
    input  wire logic         i_halted,
    input  wire logic         i_sleeping,
    input  wire logic         i_instr_end,
    input  wire logic         i_int_enable,
    output logic              o_irq_accept,
    output cbs_irq_t          o_irq_source,
    output logic [15:0]       o_nmi_addr,
    input  wire logic         i_nmi_n,
    input  wire logic         i_irq_line_zero_n,
    input  wire logic         i_irq_line_one_n,
    input  wire logic         i_irq_line_two_n,
    input  wire logic         i_bus_request_n,
    input  wire logic         i_wait_n,
    output logic              o_sys_clk,
    output logic [19:0]       o_addr,
    input  wire logic [7:0]   i_data,
    output logic [7:0]        o_data,
    output logic              o_data_oe,
    output logic              o_memory_request_strobe_n,
    output logic              o_io_request_strobe_n,
    output logic              o_rd_n,
    output logic              o_wr_n,
    output logic              o_refresh_strobe_n,
    output logic              o_first_cycle_strobe_n,
    output logic              o_cycle_status_pin,
    output logic              o_halt_n,
    output logic              o_dma_transfer_end_one_n,
    input  wire logic         i_timer_pulse,
    input  wire cbs_mux_cfg_t i_mux_cfg,
    input  wire logic [1:0]   i_tx_bit,
    input  wire logic [1:0]   i_tx_clk,
    output logic [1:0]        o_async_tx_data,
    input  wire logic         i_async_clock_zero,
    output logic              o_async_clock_zero,
    output logic              o_async_clock_zero_oe,
    input  wire logic         i_async_clock_zero_out,
    input  wire logic         i_async_clock_zero_drive,
    output logic              o_ch0_clk_in,
    output logic              o_dma_request_zero_n,
    input  wire logic         i_async_clock_one,
    output logic              o_async_clock_one,
    output logic              o_async_clock_one_oe,
    input  wire logic         i_async_clock_one_out,
    input  wire logic         i_async_clock_one_drive,
    output logic              o_ch1_clk_in,
    input  wire logic         i_clocked_serial_rx,
    output logic              o_clocked_serial_rx,
    output logic              o_clear_to_send_one_n
);

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    logic [PIN_NUM-1:0] pin_raw;
    logic [PIN_NUM-1:0] s1;
    logic [PIN_NUM-1:0] s2;
    logic [PIN_NUM-1:0] s3;
    logic [PIN_NUM-1:0] fin;
    logic               nmi_prev;
    logic               nmi_pend;
    cbs_state_t         state;
    cbs_req_t           cur;
    logic [1:0]         auto_wait;
    logic               ins_wait;
    logic [7:0]         refcnt;
    logic               sel_timer_pulse_out;
    logic               sel_dreq;
    logic               sel_dma_transfer_end_zero;
    logic               sel_cts;
    logic [1:0]         tx_prev;
    logic               act;
    logic               is_mem;
    logic               is_io;
    logic               is_rd;
    logic               is_wr;
    logic               is_dma;
    logic               next_dma_transfer_end;
    logic [2:0]         next_status;

    assign pin_raw = {i_clocked_serial_rx, i_async_clock_one, i_async_clock_zero,
                      i_bus_request_n, i_wait_n, i_irq_line_two_n,
                      i_irq_line_one_n, i_irq_line_zero_n, i_nmi_n};

    // A pin level is taken only once the last two stages agree, so a runt is dropped.
    genvar g;
    generate
        for (g = 0; g < PIN_NUM; g++) begin : g_sync
            always_ff @(posedge i_ref_clk) begin
                if (i_rst) begin
                    s1[g]  <= PIN_IDLE[g];
                    s2[g]  <= PIN_IDLE[g];
                    s3[g]  <= PIN_IDLE[g];
                    fin[g] <= PIN_IDLE[g];
                end else begin
                    s1[g] <= pin_raw[g];
                    s2[g] <= s1[g];
                    s3[g] <= s2[g];
                    if (s2[g] == s3[g]) begin
                        fin[g] <= s3[g];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_sys_clk <= 1'b0;
        end else begin
            o_sys_clk <= ~o_sys_clk;
        end
    end

    // Interrupt arbitration at the end of an instruction.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            nmi_prev     <= 1'b1;
            nmi_pend     <= 1'b0;
            o_irq_accept <= 1'b0;
            o_irq_source <= IRQ_NMI;
            o_nmi_addr   <= NMI_VECTOR;
        end else begin
            nmi_prev     <= fin[PIN_NMI];
            o_irq_accept <= 1'b0;
            o_nmi_addr   <= NMI_VECTOR;
            if (i_instr_end && fin[PIN_BREQ]) begin
                if (nmi_pend) begin
                    o_irq_accept <= 1'b1;
                    o_irq_source <= IRQ_NMI;
                end else if (i_int_enable && !fin[PIN_IRQ_LINE_ZERO]) begin
                    o_irq_accept <= 1'b1;
                    o_irq_source <= IRQ_ZERO;
                end else if (i_int_enable && !fin[PIN_IRQ_LINE_ONE]) begin
                    o_irq_accept <= 1'b1;
                    o_irq_source <= IRQ_ONE;
                end else if (i_int_enable && !fin[PIN_IRQ_LINE_TWO]) begin
                    o_irq_accept <= 1'b1;
                    o_irq_source <= IRQ_TWO;
                end
            end
            // A new falling edge in the accept cycle stays pending.
            if (nmi_prev && !fin[PIN_NMI]) begin
                nmi_pend <= 1'b1;
            end else if (i_instr_end && fin[PIN_BREQ]) begin
                nmi_pend <= 1'b0;
            end
        end
    end

    // Bus states advance on the rising system edge; wait is sampled on the falling one.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state     <= BS_IDLE;
            cur       <= '0;
            auto_wait <= 2'h0;
            ins_wait  <= 1'b0;
            refcnt    <= REFRESH_RESET;
            o_done    <= 1'b0;
            o_rdata   <= 8'h00;
        end else begin
            o_done <= 1'b0;
            if (o_sys_clk && (state == BS_T2 || state == BS_TW)) begin
                ins_wait <= !fin[PIN_WAIT] || (auto_wait != 2'h0);
                if (auto_wait != 2'h0) begin
                    auto_wait <= auto_wait - 2'h1;
                end
            end
            if (!o_sys_clk) begin
                case (state)
                    BS_IDLE: begin
                        if (i_req.valid) begin
                            cur   <= i_req;
                            state <= BS_T1;
                            if (i_req.kind == CYC_IO_RD || i_req.kind == CYC_IO_WR ||
                                i_req.kind == CYC_INTACK0) begin
                                auto_wait <= IO_AUTO_WAIT;
                            end else begin
                                auto_wait <= 2'h0;
                            end
                        end
                    end
                    BS_T1: state <= BS_T2;
                    BS_T2, BS_TW: state <= ins_wait ? BS_TW : BS_T3;
                    BS_T3: begin
                        state   <= BS_IDLE;
                        o_done  <= 1'b1;
                        o_rdata <= i_data;
                        if (cur.kind == CYC_REFRESH) begin
                            refcnt <= refcnt + 8'h01;
                        end
                    end
                    default: state <= BS_IDLE;
                endcase
            end
        end
    end

    always_comb begin
        act    = (state == BS_T2) || (state == BS_TW) || (state == BS_T3) ||
                 (state == BS_T1 && o_sys_clk);
        is_mem = cur.kind inside {CYC_FETCH, CYC_MEM_RD, CYC_MEM_WR, CYC_REFRESH,
                                  CYC_DMA_RD, CYC_DMA_WR};
        is_io  = cur.kind inside {CYC_IO_RD, CYC_IO_WR, CYC_INTACK0};
        is_rd  = cur.kind inside {CYC_FETCH, CYC_MEM_RD, CYC_IO_RD, CYC_DMA_RD};
        is_wr  = cur.kind inside {CYC_MEM_WR, CYC_IO_WR, CYC_DMA_WR};
        is_dma = cur.kind inside {CYC_DMA_RD, CYC_DMA_WR};
        next_dma_transfer_end = act && cur.kind == CYC_DMA_WR && cur.last_dma;
        if (i_halted) begin
            next_status = ST_HALT;
        end else if (i_sleeping) begin
            next_status = ST_SLEEP;
        end else if (act && is_dma) begin
            next_status = ST_DMA;
        end else if (act && cur.kind == CYC_FETCH) begin
            next_status = cur.first_fetch ? ST_FETCH_FIRST : ST_FETCH_NEXT;
        end else begin
            next_status = ST_OTHER;
        end
    end

    // Strobes are registered so that every pin comes from a flop; they trail the state by one.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_memory_request_strobe_n <= 1'b1;
            o_io_request_strobe_n     <= 1'b1;
            o_rd_n                    <= 1'b1;
            o_wr_n                    <= 1'b1;
            o_refresh_strobe_n        <= 1'b1;
            o_first_cycle_strobe_n    <= 1'b1;
            o_cycle_status_pin        <= ST_OTHER[2];
            o_halt_n                  <= ST_OTHER[1];
            o_dma_transfer_end_one_n  <= 1'b1;
            o_addr                    <= 20'h00000;
            o_data                    <= 8'h00;
            o_data_oe                 <= 1'b0;
        end else begin
            o_memory_request_strobe_n <= !(act && is_mem);
            o_io_request_strobe_n     <= !(act && is_io && state != BS_T1);
            o_rd_n                    <= !(act && is_rd);
            o_wr_n                    <= !(act && is_wr && state != BS_T1);
            o_refresh_strobe_n        <= !(act && cur.kind == CYC_REFRESH);
            o_first_cycle_strobe_n    <= !(i_halted ||
                (act && (cur.kind == CYC_FETCH || cur.kind == CYC_INTACK0)));
            o_cycle_status_pin        <= next_status[2];
            o_halt_n                  <= next_status[1];
            o_dma_transfer_end_one_n  <= !(next_dma_transfer_end && cur.dma_ch);
            if (cur.kind == CYC_REFRESH) begin
                o_addr[17:0] <= {10'h000, refcnt};
            end else if (is_io) begin
                o_addr[17:0] <= {2'h0, cur.addr[15:0]};
            end else begin
                o_addr[17:0] <= cur.addr[17:0];
            end
            o_addr[19] <= (is_io || cur.kind == CYC_REFRESH) ? 1'b0 : cur.addr[19];
            if (sel_timer_pulse_out) begin
                o_addr[18] <= i_timer_pulse;
            end else begin
                o_addr[18] <= (is_io || cur.kind == CYC_REFRESH) ? 1'b0 : cur.addr[18];
            end
            o_data    <= cur.wdata;
            o_data_oe <= act && is_wr;
        end
    end

    // Pin function selects fall back to their reset roles whenever the flops are cleared.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sel_timer_pulse_out              <= 1'b0;
            sel_dreq              <= 1'b0;
            sel_dma_transfer_end_zero             <= 1'b0;
            sel_cts               <= 1'b0;
            o_async_clock_zero    <= 1'b0;
            o_async_clock_zero_oe <= 1'b0;
            o_ch0_clk_in          <= 1'b0;
            o_dma_request_zero_n  <= 1'b1;
            o_async_clock_one     <= 1'b0;
            o_async_clock_one_oe  <= 1'b0;
            o_ch1_clk_in          <= 1'b0;
            o_clocked_serial_rx   <= 1'b1;
            o_clear_to_send_one_n <= 1'b1;
        end else begin
            sel_timer_pulse_out  <= i_mux_cfg.timer_pulse_out_hi || i_mux_cfg.timer_pulse_out_lo;
            sel_dreq  <= i_mux_cfg.dma_dest_hi || i_mux_cfg.dma_src_hi;
            sel_dma_transfer_end_zero <= i_mux_cfg.async_clock_one_disable;
            sel_cts   <= i_mux_cfg.clear_to_send_one_enable;
            o_async_clock_zero    <= i_async_clock_zero_out;
            o_async_clock_zero_oe <= !sel_dreq && i_async_clock_zero_drive;
            o_ch0_clk_in          <= sel_dreq ? 1'b0 : fin[PIN_ASYNC_CLOCK_ZERO];
            o_dma_request_zero_n  <= sel_dreq ? fin[PIN_ASYNC_CLOCK_ZERO] : 1'b1;
            o_async_clock_one     <= sel_dma_transfer_end_zero ? !(next_dma_transfer_end && !cur.dma_ch) : i_async_clock_one_out;
            o_async_clock_one_oe  <= sel_dma_transfer_end_zero || i_async_clock_one_drive;
            o_ch1_clk_in          <= sel_dma_transfer_end_zero ? 1'b0 : fin[PIN_ASYNC_CLOCK_ONE];
            o_clocked_serial_rx   <= sel_cts ? 1'b1 : fin[PIN_RXS];
            o_clear_to_send_one_n <= sel_cts ? fin[PIN_RXS] : 1'b1;
        end
    end

    generate
        for (g = 0; g < 2; g++) begin : g_tx
            always_ff @(posedge i_ref_clk) begin
                if (i_rst) begin
                    tx_prev[g]         <= 1'b0;
                    o_async_tx_data[g] <= TX_IDLE;
                end else begin
                    tx_prev[g] <= i_tx_clk[g];
                    if (tx_prev[g] && !i_tx_clk[g]) begin
                        o_async_tx_data[g] <= i_tx_bit[g];
                    end
                end
            end
        end
    endgenerate

    sequence s_wait_low;
        state == BS_TW && o_sys_clk && !fin[PIN_WAIT];
    endsequence

    sequence s_stay_wait;
        ##2 state == BS_TW;
    endsequence

    a_refresh_pair: assert property (!o_refresh_strobe_n |-> !o_memory_request_strobe_n)
        else $error("refresh strobe without memory strobe");
    a_fetch_m1_mem: assert property (!o_first_cycle_strobe_n && !o_memory_request_strobe_n
        |-> cur.kind == CYC_FETCH)
        else $error("first-cycle with memory strobe outside fetch");
    a_ack_m1_io: assert property (!o_io_request_strobe_n && !o_first_cycle_strobe_n
        |-> cur.kind == CYC_INTACK0)
        else $error("first-cycle with I/O strobe outside acknowledge");
    a_wait_hold: assert property (s_wait_low |-> s_stay_wait)
        else $error("wait low did not hold the wait state");
    a_nmi_first: assert property (o_irq_accept && $past(nmi_pend)
        |-> o_irq_source == IRQ_NMI)
        else $error("maskable request won over pending NMI");
    a_line_one_order: assert property (o_irq_accept && o_irq_source == IRQ_ONE
        |-> $past(fin[PIN_IRQ_LINE_ZERO]) && !$past(nmi_pend))
        else $error("line one taken over a higher request");
    a_tx_on_fall: assert property ($changed(o_async_tx_data[0])
        |-> $past(tx_prev[0]) && !$past(i_tx_clk[0]))
        else $error("transmit data changed off the clock fall");
    a_timer_pulse_out_route: assert property ($past(sel_timer_pulse_out) |-> o_addr[18] == $past(i_timer_pulse))
        else $error("address 18 pin not carrying timer output");
    a_wr_data: assert property (!o_wr_n |-> o_data_oe)
        else $error("write strobe without driven data");
    a_io_strobe: assert property (!o_io_request_strobe_n |-> o_memory_request_strobe_n)
        else $error("I/O and memory strobes together");

endmodule : cbs_bus_ctl

// [testbench/cbs_ext_dev.sv]
`timescale 1ns/10ps
module cbs_ext_dev (
    input  wire logic       i_ref_clk,
    input  wire logic       i_sel_n,
    input  wire logic       i_rd_n,
    input  wire logic [7:0] i_addr,
    input  wire logic [4:0] i_wait_len,
    output logic [7:0]      o_data,
    output logic            o_wait_n
);
    logic [4:0] wait_left = 5'h00;
    logic [7:0] last_data = 8'h00;
    // A slow device holds wait low ahead of selection, since the pin sync is slower than T2.
    always_ff @(posedge i_ref_clk) begin
        if (i_sel_n) begin
            wait_left <= i_wait_len;
        end else if (wait_left != 5'h00) begin
            wait_left <= wait_left - 5'h01;
        end
        if (!i_rd_n) begin
            last_data <= i_addr ^ 8'h5a;
        end
    end
    assign o_wait_n = (wait_left == 5'h00);
    // Nothing pulls the bus, so once released it shows the inverse, never a stale byte.
    assign o_data = i_rd_n ? ~last_data : (i_addr ^ 8'h5a);
endmodule : cbs_ext_dev

// [testbench/cpu_bus_status_and_pin_mux_test.sv]
`timescale 1ns/10ps
module cpu_bus_status_and_pin_mux_test;
    import cbs_pkg::*;
    logic i_ref_clk, i_rst = 1'b1, i_halted = 1'b0, i_sleeping = 1'b0, i_instr_end = 1'b0;
    logic i_int_enable = 1'b0, i_nmi_n = 1'b1, i_bus_request_n = 1'b1, i_timer_pulse = 1'b0;
    logic i_irq_line_zero_n = 1'b1, i_irq_line_one_n = 1'b1, i_irq_line_two_n = 1'b1;
    logic i_async_clock_zero = 1'b1, i_async_clock_zero_out = 1'b0, i_async_clock_zero_drive = 1'b0;
    logic i_async_clock_one = 1'b1, i_async_clock_one_out = 1'b0, i_async_clock_one_drive = 1'b0;
    logic i_clocked_serial_rx = 1'b1;
    logic [1:0] i_tx_bit = 2'h3, i_tx_clk = 2'h0;
    cbs_req_t i_req = '0;
    cbs_mux_cfg_t i_mux_cfg = '0;
    logic [4:0] wait_len = 5'h00;
    wire logic i_wait_n;
    wire logic [7:0] i_data, ext_data;
    logic o_done, o_irq_accept, o_sys_clk, o_data_oe, o_memory_request_strobe_n, o_rd_n, o_wr_n;
    logic o_io_request_strobe_n, o_refresh_strobe_n, o_first_cycle_strobe_n, o_halt_n;
    logic o_cycle_status_pin, o_dma_transfer_end_one_n, o_async_clock_zero, o_ch0_clk_in;
    logic o_async_clock_zero_oe, o_dma_request_zero_n, o_async_clock_one, o_async_clock_one_oe;
    logic o_ch1_clk_in, o_clocked_serial_rx, o_clear_to_send_one_n;
    cbs_irq_t o_irq_source;
    logic [15:0] o_nmi_addr;
    logic [19:0] o_addr;
    logic [7:0] o_rdata, o_data;
    logic [1:0] o_async_tx_data;
    int error_cnt = 0, checks_done = 0, cyc_cnt = 0, n0, n1;

    assign i_data = o_data_oe ? o_data : ext_data;
    cbs_ext_dev ext (.i_ref_clk, .i_sel_n(o_memory_request_strobe_n & o_io_request_strobe_n),
        .i_rd_n(o_rd_n), .i_addr(o_addr[7:0]), .i_wait_len(wait_len), .o_data(ext_data),
        .o_wait_n(i_wait_n));
    cbs_bus_ctl dut (.i_ref_clk, .i_rst, .i_req, .o_done, .o_rdata, .i_halted, .i_sleeping,
        .i_instr_end, .i_int_enable, .o_irq_accept, .o_irq_source, .o_nmi_addr, .i_nmi_n,
        .i_irq_line_zero_n, .i_irq_line_one_n, .i_irq_line_two_n, .i_bus_request_n, .i_wait_n,
        .o_sys_clk, .o_addr, .i_data, .o_data, .o_data_oe, .o_memory_request_strobe_n,
        .o_io_request_strobe_n, .o_rd_n, .o_wr_n, .o_refresh_strobe_n, .o_first_cycle_strobe_n,
        .o_cycle_status_pin, .o_halt_n, .o_dma_transfer_end_one_n, .i_timer_pulse, .i_mux_cfg,
        .i_tx_bit, .i_tx_clk, .o_async_tx_data, .i_async_clock_zero, .o_async_clock_zero,
        .o_async_clock_zero_oe, .i_async_clock_zero_out, .i_async_clock_zero_drive, .o_ch0_clk_in, .o_dma_request_zero_n,
        .i_async_clock_one, .o_async_clock_one, .o_async_clock_one_oe, .i_async_clock_one_out, .i_async_clock_one_drive,
        .o_ch1_clk_in, .i_clocked_serial_rx, .o_clocked_serial_rx, .o_clear_to_send_one_n);

    initial begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // The whole run needs a few hundred cycles, so this only cuts a real hang.
    always @(posedge i_ref_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : tick

    task automatic expect_eq(input logic [19:0] got, input logic [19:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : expect_eq

    // Seen order is transfer-end, memory, I/O, read, write, refresh, first-cycle.
    task automatic run_cyc(input cbs_cycle_t k, input logic ff, input logic [19:0] a,
                           input logic [4:0] nw, input logic [6:0] exp_seen,
                           input logic [2:0] exp_st, input logic [19:0] exp_ad, output int n);
        logic [6:0] seen;
        logic [2:0] st;
        logic [19:0] ad;
        seen = 7'h00;
        st = 3'h0;
        ad = 20'h00000;
        n = 0;
        wait_len = nw;
        if (nw != 5'h00) begin
            tick(6);
        end
        i_req = '{1'b1, k, ff, 1'b1, 1'b1, a, 8'hc3};
        do begin
            tick(1);
            n++;
            seen |= ~{o_dma_transfer_end_one_n, o_memory_request_strobe_n, o_io_request_strobe_n,
                      o_rd_n, o_wr_n, o_refresh_strobe_n, o_first_cycle_strobe_n};
            if (!(o_memory_request_strobe_n && o_io_request_strobe_n)) begin
                st = {o_cycle_status_pin, o_halt_n, o_first_cycle_strobe_n};
                ad = o_addr;
            end
        end while (o_done !== 1'b1 && n < 100);
        i_req.valid = 1'b0;
        wait_len = 5'h00;
        tick(1);
        expect_eq(20'(seen), 20'(exp_seen), "strobes seen");
        expect_eq(20'(st), 20'(exp_st), "status code");
        expect_eq(ad, exp_ad, "address");
        if (k == CYC_FETCH || k == CYC_MEM_RD || k == CYC_IO_RD) begin
            expect_eq(20'(o_rdata), 20'(a[7:0] ^ 8'h5a), "read data");
        end
    endtask : run_cyc

    task automatic irq_try(input logic exp_acc, input cbs_irq_t exp_src);
        logic acc;
        cbs_irq_t src;
        acc = 1'b0;
        src = IRQ_NMI;
        tick(8);
        i_instr_end = 1'b1;
        tick(1);
        i_instr_end = 1'b0;
        repeat (3) begin
            if (o_irq_accept === 1'b1) begin
                acc = 1'b1;
                src = o_irq_source;
            end
            tick(1);
        end
        expect_eq(20'(acc), 20'(exp_acc), "accept");
        if (exp_acc) begin
            expect_eq(20'(src), 20'(exp_src), "source");
        end
    endtask : irq_try

    task automatic mux_set(input logic [5:0] cfg, input logic pulse);
        i_mux_cfg = cfg;
        i_timer_pulse = pulse;
        tick(6);
    endtask : mux_set

    initial begin
        tick(4);
        i_rst = 1'b0;
        tick(6);
        n0 = o_sys_clk;
        repeat (4) begin
            tick(1);
            expect_eq(20'(o_sys_clk), 20'(!n0[0]), "system clock");
            n0 = o_sys_clk;
        end
        run_cyc(CYC_FETCH, 1'b1, 20'h01234, 0, 7'h29, ST_FETCH_FIRST, 20'h01234, n0);
        run_cyc(CYC_FETCH, 1'b0, 20'h01235, 0, 7'h29, ST_FETCH_NEXT, 20'h01235, n0);
        run_cyc(CYC_MEM_RD, 1'b0, 20'h23456, 0, 7'h28, ST_OTHER, 20'h23456, n0);
        run_cyc(CYC_MEM_RD, 1'b0, 20'h23457, 12, 7'h28, ST_OTHER, 20'h23457, n1);
        expect_eq(20'(n1 > n0 + 3), 20'h00001, "wait stretch");
        run_cyc(CYC_MEM_WR, 1'b0, 20'h3abcd, 0, 7'h24, ST_OTHER, 20'h3abcd, n0);
        run_cyc(CYC_IO_RD, 1'b0, 20'hf0081, 0, 7'h18, ST_OTHER, 20'h00081, n0);
        run_cyc(CYC_IO_WR, 1'b0, 20'hf0082, 0, 7'h14, ST_OTHER, 20'h00082, n0);
        run_cyc(CYC_REFRESH, 1'b0, 20'h0ffff, 0, 7'h22, ST_OTHER, 20'h00000, n0);
        run_cyc(CYC_INTACK0, 1'b0, 20'h00000, 0, 7'h11, 3'h6, 20'h00000, n0);
        run_cyc(CYC_DMA_WR, 1'b0, 20'h31111, 0, 7'h64, ST_DMA, 20'h31111, n0);
        i_int_enable = 1'b1;
        i_irq_line_zero_n = 1'b0;
        i_nmi_n = 1'b0;
        irq_try(1'b1, IRQ_NMI);
        expect_eq(20'(o_nmi_addr), 20'h00066, "restart address");
        i_bus_request_n = 1'b0;
        irq_try(1'b0, IRQ_ZERO);
        i_bus_request_n = 1'b1;
        irq_try(1'b1, IRQ_ZERO);
        i_irq_line_zero_n = 1'b1;
        i_irq_line_one_n = 1'b0;
        i_irq_line_two_n = 1'b0;
        irq_try(1'b1, IRQ_ONE);
        i_irq_line_one_n = 1'b1;
        irq_try(1'b1, IRQ_TWO);
        i_int_enable = 1'b0;
        irq_try(1'b0, IRQ_TWO);
        i_irq_line_two_n = 1'b1;
        i_async_clock_zero = 1'b0;
        i_async_clock_one = 1'b0;
        i_clocked_serial_rx = 1'b0;
        mux_set(6'h10, 1'b1);
        expect_eq(20'(o_addr[18]), 20'h00001, "timer pin high");
        mux_set(6'h20, 1'b0);
        expect_eq(20'(o_addr[18]), 20'h00000, "timer pin low");
        mux_set(6'h04, 1'b1);
        expect_eq(20'(o_addr[18]), 20'h00000, "address pin back");
        expect_eq(20'({o_dma_request_zero_n, o_async_clock_zero_oe}), 20'h0, "request zero");
        mux_set(6'h0b, 1'b1);
        expect_eq(20'(o_dma_request_zero_n), 20'h00000, "request zero dest");
        expect_eq(20'({o_async_clock_one_oe, o_async_clock_one}), 20'h3, "end zero idle");
        expect_eq(20'({o_clear_to_send_one_n, o_clocked_serial_rx}), 20'h1, "cts sel");
        i_async_clock_zero_drive = 1'b1;
        i_async_clock_zero_out = 1'b1;
        mux_set(6'h00, 1'b1);
        expect_eq(20'({o_async_clock_zero_oe, o_async_clock_zero}), 20'h3, "clock zero");
        expect_eq(20'(o_dma_request_zero_n), 20'h00001, "request zero off");
        expect_eq(20'({o_async_clock_one_oe, o_ch1_clk_in}), 20'h0, "clock one in");
        expect_eq(20'({o_clear_to_send_one_n, o_clocked_serial_rx}), 20'h2, "rx sel");
        i_tx_clk = 2'h3;
        i_tx_bit = 2'h0;
        tick(3);
        expect_eq(20'(o_async_tx_data), 20'h00003, "tx held");
        i_tx_clk = 2'h2;
        tick(3);
        expect_eq(20'(o_async_tx_data), 20'h00002, "tx on fall");
        i_halted = 1'b1;
        tick(4);
        expect_eq(20'({o_cycle_status_pin, o_halt_n, o_first_cycle_strobe_n}), 20'(ST_HALT),
                  "halt code");
        i_halted = 1'b0;
        i_sleeping = 1'b1;
        tick(4);
        expect_eq(20'({o_cycle_status_pin, o_halt_n, o_first_cycle_strobe_n}), 20'(ST_SLEEP),
                  "sleep code");
        close_out();
    end
endmodule : cpu_bus_status_and_pin_mux_test
